// *** hdl/ssr_supervisor.sv ***
`timescale 1ns/10ps
`include "ssr_consts.svh"
module ssr_supervisor #(
   parameter bit RESET_ACTIVE_HIGH = 1'b1,
   parameter logic [`SSR_CNT_W-1:0] HOLD_CYC = `SSR_HOLD_CYC,
   parameter logic [`SSR_FLT_W-1:0] GLITCH_CYC = `SSR_FLT_W'(`SSR_GLITCH_CYC)
) (
   input wire logic i_clk,
   input wire logic i_resetn,
   input wire ssr_pkg::ssr_supply_t i_supply,
   input wire logic i_manual_reset_n,
   input wire logic i_manual_reset_n_oe,
   output logic o_reset,
   output logic o_overvoltage_flag_n_o,
   output logic o_overvoltage_flag_n_oe
);

   // ----------------------------------------
   // manual reset pull-up and debounce
   // ----------------------------------------
   localparam logic [`SSR_FLT_W-1:0] MR_CYC = `SSR_FLT_W'(`SSR_MR_CYC);
   logic mr_in;
   logic mr_act_reg, mr_act_next;
   logic [`SSR_FLT_W-1:0] mr_cnt_reg, mr_cnt_next;

   // undriven pin reads high
   assign mr_in = i_manual_reset_n_oe ? i_manual_reset_n : 1'b1;

   always_comb begin
      mr_act_next = mr_act_reg;
      mr_cnt_next = '0;
      if ((!mr_in) != mr_act_reg) begin
         // level must stand MR_CYC cycles before it is taken
         if (mr_cnt_reg >= MR_CYC - `SSR_FLT_W'(1)) begin
            mr_act_next = !mr_in;
         end else begin
            mr_cnt_next = mr_cnt_reg + `SSR_FLT_W'(1);
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         mr_act_reg <= 1'b0;
         mr_cnt_reg <= '0;
      end else begin
         mr_act_reg <= mr_act_next;
         mr_cnt_reg <= mr_cnt_next;
      end
   end

   // ----------------------------------------
   // supply glitch filters
   // ----------------------------------------
   logic uv_reg, uv_next, ov_reg, ov_next;
   logic [`SSR_FLT_W-1:0] uv_cnt_reg, uv_cnt_next, ov_cnt_reg, ov_cnt_next;

   always_comb begin
      uv_next = uv_reg;
      ov_next = ov_reg;
      uv_cnt_next = '0;
      ov_cnt_next = '0;
      // excursion must persist GLITCH_CYC cycles to count
      if (i_supply.under != uv_reg) begin
         if (uv_cnt_reg >= GLITCH_CYC - `SSR_FLT_W'(1)) begin
            uv_next = i_supply.under;
         end else begin
            uv_cnt_next = uv_cnt_reg + `SSR_FLT_W'(1);
         end
      end
      if (i_supply.over != ov_reg) begin
         if (ov_cnt_reg >= GLITCH_CYC - `SSR_FLT_W'(1)) begin
            ov_next = i_supply.over;
         end else begin
            ov_cnt_next = ov_cnt_reg + `SSR_FLT_W'(1);
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         uv_reg <= 1'b0;
         ov_reg <= 1'b0;
         uv_cnt_reg <= '0;
         ov_cnt_reg <= '0;
      end else begin
         uv_reg <= uv_next;
         ov_reg <= ov_next;
         uv_cnt_reg <= uv_cnt_next;
         ov_cnt_reg <= ov_cnt_next;
      end
   end

   // ----------------------------------------
   // reset sequencer
   // ----------------------------------------
   ssr_pkg::ssr_state_t st_reg, st_next;
   logic [`SSR_CNT_W-1:0] hold_reg, hold_next;
   logic cause;
   logic rst_reg, rst_next;
   logic hv_reg, hv_next;

   assign cause = mr_act_reg || uv_reg || ov_reg;

   always_comb begin
      st_next = st_reg;
      hold_next = hold_reg;
      case (st_reg)
         ssr_pkg::SSR_ST_RESET: begin
            hold_next = '0;
            if (!cause) begin
               st_next = ssr_pkg::SSR_ST_HOLD;
            end
         end
         ssr_pkg::SSR_ST_HOLD: begin
            // any cause restarts the full hold time
            if (cause) begin
               st_next = ssr_pkg::SSR_ST_RESET;
            end else if (hold_reg >= HOLD_CYC - `SSR_CNT_W'(1)) begin
               st_next = ssr_pkg::SSR_ST_RUN;
            end else begin
               hold_next = hold_reg + `SSR_CNT_W'(1);
            end
         end
         ssr_pkg::SSR_ST_RUN: begin
            if (cause) begin
               st_next = ssr_pkg::SSR_ST_RESET;
            end
         end
         default: begin
            st_next = ssr_pkg::SSR_ST_RESET;
         end
      endcase
      rst_next = cause || (st_next != ssr_pkg::SSR_ST_RUN);
      hv_next = ov_reg;
   end

   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         // power-on starts in reset with the hold still to run
         st_reg <= ssr_pkg::SSR_ST_RESET;
         hold_reg <= '0;
         rst_reg <= 1'b1;
         hv_reg <= 1'b0;
      end else begin
         st_reg <= st_next;
         hold_reg <= hold_next;
         rst_reg <= rst_next;
         hv_reg <= hv_next;
      end
   end

   assign o_reset = RESET_ACTIVE_HIGH ? rst_reg : !rst_reg;
   // open drain: only ever drives low
   assign o_overvoltage_flag_n_o = 1'b0;
   assign o_overvoltage_flag_n_oe = hv_reg;

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   sequence ov_seen_s;
      $rose(ov_reg);
   endsequence

   sequence cause_gone_s;
      $fell(cause);
   endsequence

   property ov_flag_p;
      @(posedge i_clk) disable iff (!i_resetn) ov_seen_s |=> hv_reg && rst_reg;
   endproperty

   property hold_min_p;
      @(posedge i_clk) disable iff (!i_resetn)
         (rst_reg && !rst_next) |-> (hold_reg == HOLD_CYC - `SSR_CNT_W'(1));
   endproperty

   ov_flag_a: assert property (ov_flag_p) else $error("overvoltage flag late");
   hold_min_a: assert property (hold_min_p) else $error("reset released early");
   cause_rst_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      cause |=> rst_reg) else $error("cause without reset");
   mr_force_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      $rose(mr_act_reg) |=> rst_reg) else $error("manual reset ignored");
   hold_start_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      cause_gone_s |=> rst_reg [*2]) else $error("reset dropped with cause");
   polarity_a: assert property (@(posedge i_clk)
      o_reset == (RESET_ACTIVE_HIGH ? rst_reg : !rst_reg))
      else $error("reset polarity wrong");
   od_low_a: assert property (@(posedge i_clk)
      o_overvoltage_flag_n_oe |-> !o_overvoltage_flag_n_o)
      else $error("flag drives high");
   glitch_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      (!ov_reg && i_supply.over && (ov_cnt_reg < GLITCH_CYC - `SSR_FLT_W'(1)))
      ##1 !i_supply.over |=> !ov_reg)
      else $error("glitch not ignored");
   mr_pull_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      (!i_manual_reset_n_oe && !mr_act_reg) |=> !mr_act_reg)
      else $error("open input caused reset");
   mr_short_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      (!mr_act_reg && !mr_in && (mr_cnt_reg < MR_CYC - `SSR_FLT_W'(1)))
      ##1 mr_in |=> !mr_act_reg)
      else $error("bounce taken as request");

endmodule

// *** hdl/ssr_consts.svh ***
`ifndef SSR_CONSTS_SVH
`define SSR_CONSTS_SVH

// clock and timing
`define SSR_CLK_MHZ 125
`define SSR_HOLD_MS 140
`define SSR_HOLD_CYC (`SSR_HOLD_MS * 1000 * `SSR_CLK_MHZ)
// manual reset must be low this long to count (ns)
`define SSR_MR_MIN_NS 2500
`define SSR_MR_CYC ((`SSR_MR_MIN_NS * `SSR_CLK_MHZ) / 1000)
// supply excursions shorter than this are ignored (ns)
`define SSR_GLITCH_NS 8000
`define SSR_GLITCH_CYC ((`SSR_GLITCH_NS * `SSR_CLK_MHZ) / 1000)
`define SSR_CNT_W 32
`define SSR_FLT_W 12

`endif

// *** hdl/ssr_pkg.sv ***
package ssr_pkg;
   typedef struct packed {
      logic under;
      logic over;
   } ssr_supply_t;

   typedef enum logic [1:0] {
      SSR_ST_RESET = 2'b00,
      SSR_ST_HOLD = 2'b01,
      SSR_ST_RUN = 2'b10
   } ssr_state_t;
endpackage

// *** testbench/ssr_proc_model.sv ***
`timescale 1ns/10ps
module ssr_proc_model (
   input wire logic i_clk,
   output logic o_mr_n,
   output logic o_mr_oe
);
   initial begin
      o_mr_n = 1'b1;
      o_mr_oe = 1'b0;
   end
   // switch closes and stays closed until released
   task automatic press();
      @(posedge i_clk);
      #1 o_mr_oe = 1'b1;
      o_mr_n = 1'b0;
   endtask
   // an open pin settles at the pull-up level
   task automatic release_pin();
      @(posedge i_clk);
      #1 o_mr_oe = 1'b0;
      o_mr_n = 1'b1;
   endtask
   // contact bounce: lows far shorter than the minimum width
   task automatic bounce(input int n);
      repeat (n) begin
         press();
         repeat (20) @(posedge i_clk);
         release_pin();
         repeat (3) @(posedge i_clk);
      end
   endtask
   // pin left open while a stray low sits on the line
   task automatic open_low();
      @(posedge i_clk);
      #1 o_mr_oe = 1'b0;
      o_mr_n = 1'b0;
   endtask
endmodule

// *** testbench/test_supply_supervisor_reset.sv ***
`timescale 1ns/10ps
`include "ssr_consts.svh"
module test_supply_supervisor_reset;
   localparam int HOLD = 50;
   localparam int FLT = 4;
   localparam logic [31:0] HOLD_TB = 32'h0000_0032;
   localparam logic [11:0] FLT_TB = 12'h004;
   logic i_clk = 1'b0;
   logic i_resetn = 1'b0;
   ssr_pkg::ssr_supply_t sup = '0;
   logic mr_n, mr_oe, rst_hi, rst_lo, ov_o, ov_oe;
   int miscompares = 0;
   int checks_done = 0;
   always #4 i_clk = ~i_clk;
   ssr_supervisor #(.RESET_ACTIVE_HIGH(1'b1), .HOLD_CYC(HOLD_TB), .GLITCH_CYC(FLT_TB))
      i_dut (.i_clk(i_clk), .i_resetn(i_resetn), .i_supply(sup), .i_manual_reset_n(mr_n),
      .i_manual_reset_n_oe(mr_oe), .o_reset(rst_hi), .o_overvoltage_flag_n_o(ov_o),
      .o_overvoltage_flag_n_oe(ov_oe));
   ssr_supervisor #(.RESET_ACTIVE_HIGH(1'b0), .HOLD_CYC(HOLD_TB), .GLITCH_CYC(FLT_TB))
      i_dut_low (.i_clk(i_clk), .i_resetn(i_resetn), .i_supply(sup), .i_manual_reset_n(mr_n),
      .i_manual_reset_n_oe(mr_oe), .o_reset(rst_lo), .o_overvoltage_flag_n_o(),
      .o_overvoltage_flag_n_oe());
   ssr_proc_model i_proc (.i_clk(i_clk), .o_mr_n(mr_n), .o_mr_oe(mr_oe));
   task automatic step(input int n);
      repeat (n) @(posedge i_clk);
      #1;
   endtask
   task automatic check(input string name, input logic exp, input logic seen);
      checks_done++;
      if (seen !== exp) begin
         miscompares++;
         $display("Error %s expected %b seen %b", name, exp, seen);
      end
   endtask
   task automatic rst_is(input logic a);
      check("reset_high_variant", a, rst_hi);
      check("reset_low_variant", ~a, rst_lo);
   endtask
   task automatic hold_check();
      int n;
      n = 0;
      while (rst_hi === 1'b1 && n < HOLD + 20) begin
         step(1);
         n++;
      end
      check("hold_min", 1'b1, n >= HOLD);
      rst_is(1'b0);
   endtask
   task automatic power_on();
      step(10);
      i_resetn = 1'b1;
      step(1);
      rst_is(1'b1);
      check("flag_oe_idle", 1'b0, ov_oe);
      hold_check();
   endtask
   task automatic over_event();
      sup.over = 1'b1;
      step(FLT + 3);
      rst_is(1'b1);
      check("flag_oe", 1'b1, ov_oe);
      check("flag_data", 1'b0, ov_o);
      sup.over = 1'b0;
      hold_check();
      check("flag_oe_off", 1'b0, ov_oe);
   endtask
   // second cause midway through the hold restarts it
   task automatic under_event();
      sup.under = 1'b1;
      step(FLT + 3);
      rst_is(1'b1);
      sup.under = 1'b0;
      step(HOLD / 2);
      sup.under = 1'b1;
      step(FLT + 3);
      sup.under = 1'b0;
      hold_check();
   endtask
   task automatic glitches();
      sup.over = 1'b1;
      step(FLT - 2);
      sup.over = 1'b0;
      step(3);
      sup.under = 1'b1;
      step(FLT - 2);
      sup.under = 1'b0;
      step(20);
      rst_is(1'b0);
      check("flag_oe_glitch", 1'b0, ov_oe);
   endtask
   task automatic manual();
      i_proc.bounce(5);
      step(5);
      rst_is(1'b0);
      i_proc.press();
      step(`SSR_MR_CYC + 5);
      rst_is(1'b1);
      i_proc.release_pin();
      // the release passes the same debounce before the hold starts
      step(`SSR_MR_CYC);
      rst_is(1'b1);
      hold_check();
      i_proc.open_low();
      step(`SSR_MR_CYC + 20);
      rst_is(1'b0);
      i_proc.release_pin();
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      power_on();
      over_event();
      under_event();
      glitches();
      manual();
      end_of_test();
   end
   initial begin
      #100000;
      miscompares++;
      end_of_test();
   end
endmodule
